// ===== link_phy.sv
// frame layer of the half-duplex programming link: sync, rx, tx, guard
// assumes the link clock and data pin are asynchronous to core_clk
`timescale 1ns/100ps

module link_phy
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       link_clk,
   input  wire logic       link_data_in,
   input  wire logic       tx_start,
   input  wire logic [7:0] tx_byte,
   input  wire logic [7:0] guard_bits,
   output logic            rx_valid,
   output logic [7:0]      rx_byte,
   output logic            rx_exc,
   output logic            rx_brk,
   output logic            tx_done,
   output logic            data_out,
   output logic            data_oe
);

   // =====================================================
   // pin synchronisers, three stages, change taken when 2 and 3 agree
   logic [1:0]  s1_reg, s2_reg, s3_reg, f_reg;
   logic [1:0]  f_next;
   logic        lc_rise, lc_fall, line;
   logic        rx_busy_reg, tx_act_reg;
   logic [3:0]  rcnt_reg, tcnt_reg;
   logic [10:0] sh_reg;
   logic [10:0] nf;
   logic [11:0] frame_reg;
   logic [7:0]  idle_reg;
   logic        rx_end, is_brk, is_ferr, is_perr, coll;

   assign f_next  = (s2_reg ~^ s3_reg) & s2_reg | (s2_reg ^ s3_reg) & f_reg;
   assign lc_rise = f_next[0] & ~f_reg[0];
   assign lc_fall = ~f_next[0] & f_reg[0];
   assign line    = f_next[1];

   always_ff @(posedge core_clk)
      if (rst)
      begin
         s1_reg <= 2'h3;
         s2_reg <= 2'h3;
         s3_reg <= 2'h3;
         f_reg  <= 2'h3;
      end
      else if (ce)
      begin
         s1_reg <= {link_data_in, link_clk};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         f_reg  <= f_next;
      end

   // =====================================================
   // receive: sample on rising link clock, only while not sending
   assign nf      = {line, sh_reg[10:1]};
   assign rx_end  = lc_rise & rx_busy_reg & (rcnt_reg == prog_pkg::RX_LAST);
   assign is_brk  = ~|nf;
   assign is_ferr = nf[10:9] != 2'h3;
   assign is_perr = ^nf[8:0]; // even parity over data and parity bit

   always_ff @(posedge core_clk)
      if (rst)
      begin
         rx_busy_reg <= 1'b0;
         rcnt_reg    <= 4'h0;
         sh_reg      <= 11'h000;
         rx_valid    <= 1'b0;
         rx_exc      <= 1'b0;
         rx_brk      <= 1'b0;
         rx_byte     <= 8'h00;
      end
      else if (ce)
      begin
         rx_valid <= rx_end & ~is_brk & ~is_ferr & ~is_perr;
         rx_brk   <= rx_end & is_brk;
         rx_exc   <= rx_end & ~is_brk & (is_ferr | is_perr) | coll;
         if (rx_end)
            rx_byte <= nf[7:0];
         if (lc_rise & ~tx_act_reg)
         begin
            if (!rx_busy_reg)
            begin
               rx_busy_reg <= ~line;
               rcnt_reg    <= 4'h0;
            end
            else
            begin
               sh_reg      <= nf;
               rcnt_reg    <= rcnt_reg + 4'h1;
               rx_busy_reg <= ~rx_end;
            end
         end
      end

   // =====================================================
   // transmit: idle bits first, then frame; ones drive only once
   // collision watch only while our driver is off inside the frame
   assign coll = lc_rise & tx_act_reg & (idle_reg == 8'h00)
                 & (tcnt_reg != 4'h0) & ~data_oe & ~line;

   always_ff @(posedge core_clk)
      if (rst)
      begin
         tx_act_reg <= 1'b0;
         idle_reg   <= 8'h00;
         tcnt_reg   <= 4'h0;
         frame_reg  <= 12'h000;
         data_out   <= 1'b1;
         data_oe    <= 1'b0;
         tx_done    <= 1'b0;
      end
      else if (ce)
      begin
         tx_done <= 1'b0;
         if (tx_start)
         begin
            tx_act_reg <= 1'b1;
            idle_reg   <= guard_bits + prog_pkg::IDLE_MIN;
            tcnt_reg   <= 4'h0;
            frame_reg  <= {2'h3, ^tx_byte, tx_byte, 1'b0};
         end
         else if (coll)
         begin
            tx_act_reg <= 1'b0; // stop at once, back to receive
            data_out   <= 1'b1;
            data_oe    <= 1'b0;
         end
         else if (lc_rise & tx_act_reg & (idle_reg == 8'h00)
                  & (tcnt_reg == prog_pkg::TX_BITS))
         begin
            // end on the rise of the last stop bit: a programmer that
            // stops its clock after the frame gives no further fall
            tx_act_reg <= 1'b0;
            data_out   <= 1'b1;
            data_oe    <= 1'b0;
            tx_done    <= 1'b1;
         end
         else if (lc_fall & tx_act_reg)
         begin
            if (idle_reg != 8'h00)
               idle_reg <= idle_reg - 8'h01;
            else if (tcnt_reg != prog_pkg::TX_BITS)
            begin
               data_out  <= frame_reg[0];
               data_oe   <= ~frame_reg[0] | ~data_out;
               frame_reg <= {1'b1, frame_reg[11:1]};
               tcnt_reg  <= tcnt_reg + 4'h1;
            end
         end
      end

   // =====================================================
   // checks
   a_guard_load: assert property (@(posedge core_clk) disable iff (rst)
      ce && tx_start
      |=> idle_reg == $past(guard_bits) + prog_pkg::IDLE_MIN)
      else $error("guard idle count not loaded");

   a_break_flag: assert property (@(posedge core_clk) disable iff (rst)
      ce && rx_end && is_brk |=> rx_brk && !rx_valid)
      else $error("all-zero frame not flagged as break");

endmodule

// ===== prog_host.sv
// behavioural programmer at the far side of the two-wire link
// assumes the bench resolves the wire with a pull-up when nobody drives
`timescale 1ns/100ps

// =====================================================
// programmer model
module prog_host
(
   output logic      link_clk,
   output logic      drv_oe,
   output logic      drv_bit,
   input  wire logic line
);
   // link idle high, clock stands still between frames
   initial
   begin
      link_clk = 1'b1;
      drv_oe = 1'b0;
      drv_bit = 1'b1;
   end

   // one bit: data moves a core cycle after the falling edge
   // every change lands on a core falling edge, away from sampling
   task automatic bitcyc(input logic oe, input logic v, output logic s);
      link_clk = 1'b0;
      #20 drv_oe = oe;
      drv_bit = v;
      #60 link_clk = 1'b1;
      #60 s = line;
      #20;
   endtask

   // whole frame, one idle bit ahead; bad flips parity, brk sends zeros
   task automatic send(input logic [7:0] d, input logic bad = 0,
                       input logic brk = 0);
      logic [11:0] f;
      logic        s;
      f = brk ? 12'h000 : {2'b11, ^d ^ bad, d, 1'b0};
      bitcyc(1'b0, 1'b1, s);
      for (int i = 0; i < 12; i++)
         bitcyc(1'b1, f[i], s);
      drv_oe = 1'b0;
   endtask

   // clock the wire until a start bit, then take the frame
   task automatic recv(output logic [7:0] d, output logic ok,
                       output int ni);
      logic [11:0] f;
      logic        s;
      int          n;
      n = 0;
      s = 1'b1;
      while (s && n < 300)
      begin
         bitcyc(1'b0, 1'b1, s);
         n++;
      end
      ni = n - 1; // idle bits seen ahead of the start bit
      f[0] = s;
      for (int i = 1; i < 12; i++)
         bitcyc(1'b0, 1'b1, f[i]);
      d = f[8:1];
      ok = !f[0] && !(^f[9:1]) && f[11] && f[10];
   endtask
endmodule

// ===== prog_iface_instruction_decoder.sv
// instruction decoder of the two-wire programming link
// assumes a data-space and an io-space port answering one cycle after
// their read strobe; the link pins are asynchronous to core_clk
`timescale 1ns/100ps

module prog_iface_instruction_decoder
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       link_clk,
   input  wire logic       link_data_in,
   output logic            link_data_out,
   output logic            link_data_oe,
   output logic [15:0]     ds_addr,
   output logic [7:0]      ds_wdata,
   output logic            ds_we,
   output logic            ds_re,
   input  wire logic [7:0] ds_rdata,
   output logic [5:0]      io_addr,
   output logic [7:0]      io_wdata,
   output logic            io_we,
   output logic            io_re,
   input  wire logic [7:0] io_rdata,
   output logic            prog_enabled,
   output logic            link_error
);

   // =====================================================
   // declarations
   prog_pkg::dec_state_t state_reg, state_next;
   logic [7:0]  op_reg, dec_op, rx_byte, css_rdata, guard_bits;
   logic [7:0]  tx_byte_reg, rd_data;
   logic        tx_start_reg;
   logic [15:0] ptr_reg, ptr_next;
   logic [2:0]  gt_reg;
   logic        en_next;
   logic [63:0] key_reg, key_next;
   logic [2:0]  key_cnt_reg;
   logic        rx_valid, rx_exc, rx_brk, tx_done, exc_any;
   logic        is_ld, is_st, is_ptr, is_io_rd, is_io_wr;
   logic        is_cs_rd, is_cs_wr, is_key, is_read, is_write;
   logic        post_inc, wr_now, key_set, en_clr, ptr_inc;
   logic [5:0]  io_a;
   logic [3:0]  cs_a;

   // =====================================================
   // frame layer
   link_phy u_phy
   (
      .core_clk     (core_clk),
      .rst          (rst),
      .ce           (ce),
      .link_clk     (link_clk),
      .link_data_in (link_data_in),
      .tx_start     (tx_start_reg),
      .tx_byte      (tx_byte_reg),
      .guard_bits   (guard_bits),
      .rx_valid     (rx_valid),
      .rx_byte      (rx_byte),
      .rx_exc       (rx_exc),
      .rx_brk       (rx_brk),
      .tx_done      (tx_done),
      .data_out     (link_data_out),
      .data_oe      (link_data_oe)
   );

   // =====================================================
   // opcode decode; fresh byte while idle, held opcode afterwards
   assign dec_op   = (state_reg == prog_pkg::ST_IDLE) ? rx_byte : op_reg;
   assign is_ld    = (dec_op & prog_pkg::OP_LD_MASK) == prog_pkg::OP_LD;
   assign is_st    = (dec_op & prog_pkg::OP_LD_MASK) == prog_pkg::OP_ST;
   assign is_ptr   = (dec_op & prog_pkg::OP_PTR_MASK) == prog_pkg::OP_PTR;
   assign is_io_rd = (dec_op & prog_pkg::OP_IO_MASK) == prog_pkg::OP_IO_RD;
   assign is_io_wr = (dec_op & prog_pkg::OP_IO_MASK) == prog_pkg::OP_IO_WR;
   assign is_cs_rd = (dec_op & prog_pkg::OP_CS_MASK) == prog_pkg::OP_CS_RD;
   assign is_cs_wr = (dec_op & prog_pkg::OP_CS_MASK) == prog_pkg::OP_CS_WR;
   assign is_key   = dec_op == prog_pkg::OP_KEY;
   assign is_read  = is_ld | is_io_rd | is_cs_rd;
   assign is_write = is_st | is_ptr | is_io_wr | is_cs_wr;
   assign post_inc = dec_op[prog_pkg::INC_BIT];
   assign io_a     = {dec_op[6:5], dec_op[3:0]};
   assign cs_a     = dec_op[3:0];
   assign exc_any  = rx_exc | rx_brk;

   // =====================================================
   // control/status space read and guard time decode
   // unmapped and reserved locations read as zero
   assign css_rdata =
      (cs_a == prog_pkg::CS_STATUS) ?
         {6'h00, prog_enabled, 1'b0} :
      (cs_a == prog_pkg::CS_PHYCTL) ? {5'h00, gt_reg} :
      (cs_a == prog_pkg::CS_IDENT)  ? prog_pkg::IDENT_CODE : 8'h00;
   assign guard_bits = (gt_reg == prog_pkg::GT_NONE) ? 8'h00 :
                       prog_pkg::GUARD_MAX >> gt_reg;
   assign rd_data = is_ld    ? ds_rdata :
                    is_io_rd ? io_rdata : css_rdata;

   // =====================================================
   // write, pointer and key decisions
   assign wr_now   = (state_reg == prog_pkg::ST_OPER) & rx_valid;
   assign ptr_inc  = wr_now & is_st & post_inc
                   | (state_reg == prog_pkg::ST_RD) & is_ld & post_inc;
   assign ptr_next =
      (wr_now & is_ptr) ?
         (dec_op[prog_pkg::PTR_SEL_BIT] ? {rx_byte, ptr_reg[7:0]}
                                        : {ptr_reg[15:8], rx_byte}) :
      ptr_inc ? ptr_reg + 16'h0001 : ptr_reg;
   assign key_next = {rx_byte, key_reg[63:8]};
   assign key_set  = (state_reg == prog_pkg::ST_KEY) & rx_valid
                   & (key_cnt_reg == prog_pkg::KEY_LAST)
                   & (key_next == prog_pkg::ENABLE_KEY);
   assign en_clr   = wr_now & is_cs_wr & (cs_a == prog_pkg::CS_STATUS)
                   & ~rx_byte[prog_pkg::EN_BIT];
   // a key match wins over a clear in the same cycle
   assign en_next  = key_set | prog_enabled & ~en_clr;

   // =====================================================
   // message sequencer
   always_comb
   begin
      state_next = state_reg;
      if (state_reg != prog_pkg::ST_ERR && exc_any)
         state_next = prog_pkg::ST_ERR;
      else
         unique case (state_reg)
            prog_pkg::ST_IDLE:
               if (rx_valid)
               begin
                  if (is_read)
                     state_next = prog_pkg::ST_RD;
                  else if (is_write)
                     state_next = prog_pkg::ST_OPER;
                  else if (is_key)
                     state_next = prog_pkg::ST_KEY;
               end
            prog_pkg::ST_OPER:
               if (rx_valid)
                  state_next = prog_pkg::ST_IDLE;
            prog_pkg::ST_RD:
               state_next = prog_pkg::ST_RDW;
            prog_pkg::ST_RDW:
               state_next = prog_pkg::ST_CAP;
            prog_pkg::ST_CAP:
               state_next = prog_pkg::ST_TX;
            prog_pkg::ST_TX:
               if (tx_done)
                  state_next = prog_pkg::ST_IDLE;
            prog_pkg::ST_KEY:
               if (rx_valid && key_cnt_reg == prog_pkg::KEY_LAST)
                  state_next = prog_pkg::ST_IDLE;
            prog_pkg::ST_ERR:
               if (rx_brk)
                  state_next = prog_pkg::ST_IDLE;
         endcase
   end

   always_ff @(posedge core_clk)
      if (rst)
      begin
         state_reg  <= prog_pkg::ST_IDLE;
         link_error <= 1'b0;
      end
      else if (ce)
      begin
         state_reg  <= state_next;
         link_error <= state_next == prog_pkg::ST_ERR;
      end

   // =====================================================
   // opcode, pointer, key and control registers
   always_ff @(posedge core_clk)
      if (rst)
      begin
         op_reg       <= 8'h00;
         ptr_reg      <= 16'h0000;
         gt_reg       <= prog_pkg::GT_RESET;
         prog_enabled <= 1'b0;
         key_reg      <= 64'h0;
         key_cnt_reg  <= 3'h0;
      end
      else if (ce)
      begin
         ptr_reg      <= ptr_next;
         prog_enabled <= en_next;
         if (state_reg == prog_pkg::ST_IDLE && rx_valid)
         begin
            op_reg      <= rx_byte;
            key_cnt_reg <= 3'h0;
         end
         if (state_reg == prog_pkg::ST_KEY && rx_valid)
         begin
            key_reg     <= key_next;
            key_cnt_reg <= key_cnt_reg + 3'h1;
         end
         if (wr_now && is_cs_wr && cs_a == prog_pkg::CS_PHYCTL)
            gt_reg <= rx_byte[2:0];
      end

   // =====================================================
   // data-space and io-space strobes, one cycle wide
   always_ff @(posedge core_clk)
      if (rst)
      begin
         ds_re    <= 1'b0;
         ds_we    <= 1'b0;
         ds_addr  <= 16'h0000;
         ds_wdata <= 8'h00;
         io_re    <= 1'b0;
         io_we    <= 1'b0;
         io_addr  <= 6'h00;
         io_wdata <= 8'h00;
      end
      else if (ce)
      begin
         ds_re <= (state_reg == prog_pkg::ST_RD) & is_ld;
         ds_we <= wr_now & is_st;
         io_re <= (state_reg == prog_pkg::ST_RD) & is_io_rd;
         io_we <= wr_now & is_io_wr;
         if (state_reg == prog_pkg::ST_RD || wr_now)
         begin
            ds_addr <= ptr_reg;
            io_addr <= io_a;
         end
         if (wr_now)
         begin
            ds_wdata <= rx_byte;
            io_wdata <= rx_byte;
         end
      end

   // =====================================================
   // read answer: capture one cycle after the strobe, then send
   always_ff @(posedge core_clk)
      if (rst)
      begin
         tx_start_reg <= 1'b0;
         tx_byte_reg  <= 8'h00;
      end
      else if (ce)
      begin
         tx_start_reg <= state_reg == prog_pkg::ST_CAP;
         if (state_reg == prog_pkg::ST_CAP)
            tx_byte_reg <= rd_data;
      end

   // =====================================================
   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   a_key_enables: assert property (
      ce && key_set |=> prog_enabled)
      else $error("enable key did not set programming enable");

   a_enable_cause: assert property (
      ce && !prog_enabled && !key_set |=> !prog_enabled)
      else $error("programming enabled without the key");

   a_zero_clears: assert property (
      ce && en_clr && !key_set |=> !prog_enabled)
      else $error("zero write left programming enabled");

   a_load_strobe: assert property (
      ce && state_reg == prog_pkg::ST_RD && is_ld
      |=> ds_re && ds_addr == $past(ptr_reg)
          && ptr_reg == $past(ptr_reg) + {15'h0, $past(post_inc)})
      else $error("indirect load address or pointer wrong");

   a_store_write: assert property (
      ce && wr_now && is_st
      |=> ds_we && ds_addr == $past(ptr_reg)
          && ds_wdata == $past(rx_byte))
      else $error("indirect store strobe wrong");

   a_store_inc: assert property (
      ce && wr_now && is_st && post_inc
      |=> ptr_reg == $past(ptr_reg) + 16'h0001)
      else $error("post-increment store left pointer");

   a_ptr_byte: assert property (
      ce && wr_now && is_ptr && dec_op[prog_pkg::PTR_SEL_BIT]
      |=> ptr_reg[15:8] == $past(rx_byte)
          && ptr_reg[7:0] == $past(ptr_reg[7:0]))
      else $error("pointer high byte store wrong");

   a_io_write: assert property (
      ce && wr_now && is_io_wr
      |=> io_we && io_addr == $past(io_a) && io_wdata == $past(rx_byte))
      else $error("io write strobe wrong");

   a_io_read: assert property (
      ce && state_reg == prog_pkg::ST_RD && is_io_rd
      |=> io_re && io_addr == $past(io_a))
      else $error("io read strobe wrong");

   a_read_reply: assert property (
      ce && state_reg == prog_pkg::ST_RD ##1 ce [*2]
      |=> tx_start_reg)
      else $error("read answer not started");

   a_error_entry: assert property (
      ce && state_reg != prog_pkg::ST_ERR && exc_any
      |=> state_reg == prog_pkg::ST_ERR ##0 link_error)
      else $error("exception did not enter error state");

   a_error_hold: assert property (
      ce && state_reg == prog_pkg::ST_ERR && !rx_brk
      |=> state_reg == prog_pkg::ST_ERR && !ds_we && !io_we)
      else $error("error state left without break");

endmodule

// ===== prog_pkg.sv
// constants and types shared by the programming-link decoder and its phy
// assumes a single core clock; nothing in this file holds logic
package prog_pkg;

   // =====================================================
   // opcode patterns and masks
   localparam logic [7:0] OP_LD       = 8'h20; // indirect load
   localparam logic [7:0] OP_LD_MASK  = 8'hfb; // bit 2 is post-inc
   localparam logic [7:0] OP_ST       = 8'h60; // indirect store
   localparam logic [7:0] OP_PTR      = 8'h68; // pointer byte store
   localparam logic [7:0] OP_PTR_MASK = 8'hfe;
   localparam logic [7:0] OP_IO_MASK  = 8'h90;
   localparam logic [7:0] OP_IO_RD    = 8'h10;
   localparam logic [7:0] OP_IO_WR    = 8'h90;
   localparam logic [7:0] OP_CS_MASK  = 8'hf0;
   localparam logic [7:0] OP_CS_RD    = 8'h80;
   localparam logic [7:0] OP_CS_WR    = 8'hc0;
   localparam logic [7:0] OP_KEY      = 8'he0;
   localparam int         INC_BIT     = 2;
   localparam int         PTR_SEL_BIT = 0;

   // =====================================================
   // key and control/status space
   localparam logic [63:0] ENABLE_KEY = 64'h1289ab45cdd888ff;
   localparam logic [2:0]  KEY_LAST   = 3'h7; // eighth key byte
   localparam logic [3:0]  CS_STATUS  = 4'h0;
   localparam logic [3:0]  CS_PHYCTL  = 4'h2;
   localparam logic [3:0]  CS_IDENT   = 4'hf;
   localparam int          EN_BIT     = 1;
   localparam logic [7:0]  IDENT_CODE = 8'h5a; // arbitrary value

   // =====================================================
   // guard time and frame shape
   localparam logic [2:0] GT_RESET  = 3'h0;
   localparam logic [2:0] GT_NONE   = 3'h7;
   localparam logic [7:0] GUARD_MAX = 8'h80;
   localparam logic [7:0] IDLE_MIN  = 8'h02;
   localparam logic [3:0] RX_LAST   = 4'ha; // bits after start, less one
   localparam logic [3:0] TX_BITS   = 4'hc; // start, 8 data, par, 2 stop

   typedef enum {ST_IDLE, ST_OPER, ST_RD, ST_RDW, ST_CAP, ST_TX,
                 ST_KEY, ST_ERR} dec_state_t;

endpackage

// ===== test_prog_iface_instruction_decoder.sv
// self-checking bench for the programming-link instruction decoder
// assumes prog_host.sv and the design files are compiled first
`timescale 1ns/100ps

module test_prog_iface_instruction_decoder;
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic [7:0]  ds_rdata = 8'h00;
   logic [7:0]  io_rdata = 8'h00;
   logic        link_clk, hb, hoe, dout, doe, ds_we, ds_re, io_we, io_re;
   logic        prog_enabled, link_error, ok;
   logic [15:0] ds_addr, wa, p, sd;
   logic [7:0]  ds_wdata, io_wdata, wd, iwd, d, b;
   logic [5:0]  io_addr, iwa, a;
   int          mismatches = 0;
   int          n_compared = 0;
   int          ni;
   int          gi         = 130; // default guard 128 plus two idle
   wire         line = doe ? dout : (hoe ? hb : 1'b1);

   always #10 core_clk = ~core_clk;

   prog_host host (.link_clk(link_clk), .drv_oe(hoe), .drv_bit(hb),
                   .line(line));

   prog_iface_instruction_decoder dut (.core_clk(core_clk), .rst(rst),
      .ce(1'b1), .link_clk(link_clk), .link_data_in(line),
      .link_data_out(dout), .link_data_oe(doe), .ds_addr(ds_addr),
      .ds_wdata(ds_wdata), .ds_we(ds_we), .ds_re(ds_re),
      .ds_rdata(ds_rdata), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
      .prog_enabled(prog_enabled), .link_error(link_error));

   // =====================================================
   // memory stand-ins and write capture
   function automatic logic [7:0] dsv(input logic [15:0] x);
      return x[7:0] ^ x[15:8] ^ 8'h3c;
   endfunction

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   // read data set at the falling edge, ready before the next rise
   always @(negedge core_clk)
   begin
      ds_rdata <= dsv(ds_addr);
      io_rdata <= {2'h2, io_addr};
   end

   always @(posedge core_clk)
   begin
      if (ds_we)
         {wa, wd} <= {ds_addr, ds_wdata};
      if (io_we)
         {iwa, iwd} <= {io_addr, io_wdata};
   end

   // =====================================================
   // tasks
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic end_of_test;
      if (mismatches == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic rd(input logic [7:0] op, output logic [7:0] r);
      host.send(op);
      host.recv(r, ok, ni);
      chk(ok, 1'b1);
      chk(ni >= gi, 1'b1);
   endtask

   // write message sent whole, then let the strobe land
   task automatic wr(input logic [7:0] op, input logic [7:0] v);
      host.send(op);
      host.send(v);
      repeat (10) @(negedge core_clk);
   endtask

   task automatic key(input logic [63:0] k);
      host.send(8'he0);
      for (int i = 0; i < 8; i++)
         host.send(k[8*i +: 8]);
      repeat (10) @(negedge core_clk);
   endtask

   // =====================================================
   // watchdog, far above the expected few hundred microseconds
   initial
   begin
      #1000000;
      mismatches++;
      end_of_test();
   end

   // =====================================================
   // main sequence
   initial
   begin
      sd = 16'hdea3;
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      rd(8'h82, b);
      chk(b, 8'h00);
      rd(8'h80, b);
      chk({b, prog_enabled}, 9'h000);
      rd(8'h8f, b);
      chk(b, prog_pkg::IDENT_CODE);
      wr(8'hc2, 8'h07);
      gi = 2; // guard code 7 adds no bits
      rd(8'h82, b);
      chk(b, 8'h07);
      // random pointers and data, pointer set first each time
      for (int k = 0; k < 4; k++)
      begin
         sd = lfsr(sd);
         p = sd;
         wr(8'h68, p[7:0]);
         wr(8'h69, p[15:8]);
         sd = lfsr(sd);
         d = sd[7:0];
         a = sd[13:8];
         wr(8'h64, d);
         chk({wa, wd}, {p, d});
         wr(8'h60, ~d);
         chk({wa, wd}, {p + 16'h1, ~d});
         rd(8'h24, b);
         chk(b, dsv(p + 16'h1));
         rd(8'h20, b);
         chk(b, dsv(p + 16'h2));
         rd(8'h20, b);
         chk(b, dsv(p + 16'h2));
         wr({1'b1, a[5:4], 1'b1, a[3:0]}, d);
         chk({iwa, iwd}, {a, d});
         rd({1'b0, a[5:4], 1'b1, a[3:0]}, b);
         chk(b, {2'h2, a});
      end
      key(prog_pkg::ENABLE_KEY ^ 64'h1);
      chk(prog_enabled, 1'b0);
      key(prog_pkg::ENABLE_KEY);
      b = 8'h00;
      for (int i = 0; i < 4 && b !== 8'h02; i++)
         rd(8'h80, b);
      chk(b, 8'h02);
      wr(8'hc0, 8'h02);
      chk(prog_enabled, 1'b1);
      wr(8'hc0, 8'h00);
      chk(prog_enabled, 1'b0);
      // parity fault, ignored traffic, then break to recover
      host.send(8'h20, 1'b1);
      repeat (10) @(negedge core_clk);
      chk(link_error, 1'b1);
      wr(8'h68, 8'h55);
      chk(link_error, 1'b1);
      host.send(8'h00, 1'b0, 1'b1);
      repeat (10) @(negedge core_clk);
      chk(link_error, 1'b0);
      rd(8'h8f, b);
      chk(b, prog_pkg::IDENT_CODE);
      end_of_test();
   end
endmodule
